// ---- design/pps_pkg.sv ----
// package of constants and types for the port power and fault signalling block
package pps_pkg;

	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned BLANK_TIME_US   = 200;
	localparam int unsigned MASK_TIME_US    = 10;
	localparam int unsigned RISE_TIME_US    = 50;
	localparam int unsigned SHORT_LIM_NS    = 1000;
	localparam int unsigned BLANK_CYCLES    = BLANK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned MASK_CYCLES     = MASK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned RISE_CYCLES     = RISE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SHORT_CYCLES    = SHORT_LIM_NS / CLK_PERIOD_NS;
	localparam int unsigned DET_TOGGLE_CYC  = 16;
	localparam int unsigned CNT_W           = 20;

	// ==========================================================
	// current limit decode, in mA
	localparam int unsigned LIM_W = 12;
	localparam logic [LIM_W-1:0] LIM_TABLE [8] = '{
		12'h1f4, 12'h384, 12'h3e8, 12'h4b0,
		12'h5dc, 12'h708, 12'h7d0, 12'h9c4};
	localparam logic [LIM_W-1:0] LIM_CC_MAX = 12'h5dc; // 1500 mA

	// ==========================================================
	// power states, one-hot
	typedef enum logic [3:0] {
		ST_SLEEP  = 4'h1,
		ST_DETECT = 4'h2,
		ST_ACTIVE = 4'h4,
		ST_ERROR  = 4'h8
	} pps_state_t;

	// active modes
	typedef enum logic [1:0] {
		MODE_PASS   = 2'h0,
		MODE_CDP    = 2'h1,
		MODE_DCP    = 2'h2,
		MODE_EMUL   = 2'h3
	} pps_mode_t;

endpackage : pps_pkg

// ---- design/pps_ctrl.sv ----
// control logic of the port power and fault signalling block
`timescale 1ns/1ns
module pps_ctrl (
	input  wire logic                    clock,
	input  wire logic                    resetn,
	input  wire logic                    enable_polarity_select,
	input  wire logic [2:0]              current_limit_select,
	input  wire logic                    port_power_enable,
	input  wire logic                    detect_feature_select,
	input  wire logic                    sleep_request,
	input  wire logic                    latch_mode,
	input  wire logic [1:0]              active_mode,
	input  wire logic                    dcp_accepted,
	input  wire logic                    handshake_done,
	input  wire logic                    emul_applying,
	input  wire logic                    charging,
	input  wire logic                    source_supply_ok,
	input  wire logic                    core_supply_ok,
	input  wire logic                    attach_event,
	input  wire logic                    removal_event,
	input  wire logic                    over_limit,
	input  wire logic                    over_short,
	input  wire logic                    thermal_shutdown,
	input  wire logic                    thermal_regulation,
	input  wire logic                    other_error,
	input  wire logic                    bus_low,
	input  wire logic                    bypass_overload,
	input  wire logic                    discharging,
	output logic                         fault_alert_n,
	output logic                         charging_active_n,
	output logic                         attach_detect_n,
	output logic                         data_switch_closed,
	output logic                         power_switch_on,
	output logic                         bypass_on,
	output logic                         soft_start,
	output logic                         current_clamp,
	output logic                         cc_mode,
	output logic [pps_pkg::LIM_W-1:0]    current_limit_ma
);
	import pps_pkg::*;

	// ==========================================================
	// power-up capture and blanking
	logic                 init_q, init_d;
	logic                 pol_q, pol_d;
	logic [LIM_W-1:0]     lim_q, lim_d;
	logic [CNT_W-1:0]     blank_q, blank_d;
	logic                 blanked;

	// capture straps on the first cycle after reset release
	always_comb begin
		init_d  = 1'b1;
		pol_d   = init_q ? pol_q : enable_polarity_select;
		lim_d   = init_q ? lim_q : LIM_TABLE[current_limit_select];
		blank_d = blank_q;
		if (blank_q != CNT_W'(BLANK_CYCLES))
			blank_d = blank_q + 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			init_q  <= 1'b0;
			pol_q   <= 1'b1;
			lim_q   <= LIM_TABLE[0];
			blank_q <= '0;
		end else begin
			init_q  <= init_d;
			pol_q   <= pol_d;
			lim_q   <= lim_d;
			blank_q <= blank_d;
		end
	end

	assign blanked = (blank_q != CNT_W'(BLANK_CYCLES));

	// ==========================================================
	// enable decode and edges
	logic en, en_prev_q, en_rise, en_fall;
	assign en      = init_q && (port_power_enable == pol_q);
	assign en_rise = en && !en_prev_q;
	assign en_fall = !en && en_prev_q;

	// ==========================================================
	// error filtering
	logic [CNT_W-1:0] mask_q, mask_d;
	logic             err_raw, err_now, ovl_trip;
	logic             use_trip;

	// trip when pass-through, unaccepted dcp or no handshake
	assign use_trip = (active_mode == MODE_PASS) ||
		(active_mode == MODE_DCP && !dcp_accepted) ||
		!handshake_done;
	assign ovl_trip = use_trip && over_limit;
	assign err_raw  = ovl_trip || over_short || other_error ||
		(!use_trip && bus_low);
	assign err_now  = thermal_shutdown ||
		(mask_q == CNT_W'(MASK_CYCLES) && err_raw);

	always_comb begin
		mask_d = '0;
		if (err_raw)
			mask_d = (mask_q == CNT_W'(MASK_CYCLES)) ?
				mask_q : mask_q + 1'b1;
	end

	// ==========================================================
	// power state machine
	pps_state_t       st_q, st_d;
	logic             attached_q, attached_d;
	logic [CNT_W-1:0] soft_q, soft_d;

	always_comb begin
		st_d       = st_q;
		attached_d = attached_q;
		if (attach_event && st_q == ST_DETECT)
			attached_d = 1'b1;
		if (removal_event || st_q == ST_SLEEP)
			attached_d = 1'b0;
		soft_d = (soft_q != '0) ? soft_q - 1'b1 : '0;
		if (en_rise || (attach_event && st_q == ST_DETECT && en))
			soft_d = CNT_W'(RISE_CYCLES);
		case (st_q)
			ST_SLEEP: begin
				if (!sleep_request)
					st_d = ST_DETECT;
			end
			ST_DETECT: begin
				if (sleep_request)
					st_d = ST_SLEEP;
				else if (thermal_shutdown)
					st_d = ST_ERROR;
				else if (en && source_supply_ok &&
					(!detect_feature_select || attached_d))
					st_d = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (err_now)
					st_d = ST_ERROR;
				else if (!en || !source_supply_ok ||
					(detect_feature_select && !attached_d))
					st_d = ST_DETECT;
				else if (sleep_request)
					st_d = ST_SLEEP;
			end
			ST_ERROR: begin
				// latched mode retries on the disable edge or a removal event
				if (!(err_raw || thermal_shutdown) &&
					(!latch_mode || en_fall || removal_event))
					st_d = ST_DETECT;
			end
			default: st_d = ST_SLEEP;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_q       <= ST_SLEEP;
			attached_q <= 1'b0;
			soft_q     <= '0;
			mask_q     <= '0;
			en_prev_q  <= 1'b0;
		end else begin
			st_q       <= st_d;
			attached_q <= attached_d;
			soft_q     <= soft_d;
			mask_q     <= mask_d;
			en_prev_q  <= en;
		end
	end

	// ==========================================================
	// attach overload toggle
	logic [4:0] tog_q, tog_d;
	logic       tog_ph_q, tog_ph_d;
	logic       tog_active;
	assign tog_active = detect_feature_select && en && !source_supply_ok &&
		bypass_overload;

	always_comb begin
		tog_d    = tog_active ? tog_q + 1'b1 : '0;
		tog_ph_d = tog_q == 5'(DET_TOGGLE_CYC - 1) ? !tog_ph_q : tog_ph_q;
		if (tog_q == 5'(DET_TOGGLE_CYC - 1))
			tog_d = '0;
		if (!tog_active)
			tog_ph_d = 1'b0;
	end

	// ==========================================================
	// registered outputs
	logic fa_d, ca_d, ad_d, ds_d, ps_d, by_d, cc_d, cl_d;
	logic emulating;
	assign emulating = (active_mode == MODE_DCP) ||
		(active_mode == MODE_EMUL && emul_applying);

	always_comb begin
		fa_d = blanked || st_d != ST_ERROR;
		ca_d = blanked || !charging;
		ad_d = 1'b1;
		if (attached_d || (!detect_feature_select && st_d == ST_ACTIVE))
			ad_d = 1'b0;
		if (tog_ph_q)
			ad_d = 1'b1;
		if (blanked)
			ad_d = 1'b1;
		ds_d = st_d == ST_ACTIVE && !emulating;
		if (!core_supply_ok)
			ds_d = 1'b0;
		ps_d = st_d == ST_ACTIVE && !discharging && !ovl_trip &&
			!thermal_shutdown &&
			!(!use_trip && (thermal_regulation || bus_low));
		by_d = st_d == ST_DETECT;
		cc_d = !use_trip && ((active_mode == MODE_DCP && dcp_accepted &&
			lim_q <= LIM_CC_MAX) || active_mode == MODE_CDP ||
			(active_mode == MODE_EMUL && emul_applying));
		cl_d = st_d == ST_DETECT || over_short;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			tog_q              <= '0;
			tog_ph_q           <= 1'b0;
			fault_alert_n      <= 1'b1;
			charging_active_n  <= 1'b1;
			attach_detect_n    <= 1'b1;
			data_switch_closed <= 1'b0;
			power_switch_on    <= 1'b0;
			bypass_on          <= 1'b0;
			soft_start         <= 1'b0;
			current_clamp      <= 1'b0;
			cc_mode            <= 1'b0;
			current_limit_ma   <= LIM_TABLE[0];
		end else begin
			tog_q              <= tog_d;
			tog_ph_q           <= tog_ph_d;
			fault_alert_n      <= fa_d;
			charging_active_n  <= ca_d;
			attach_detect_n    <= ad_d;
			data_switch_closed <= ds_d;
			power_switch_on    <= ps_d;
			bypass_on          <= by_d;
			soft_start         <= soft_d != '0;
			current_clamp      <= cl_d;
			cc_mode            <= cc_d;
			current_limit_ma   <= lim_q;
		end
	end

	// ==========================================================
	// checks
	property p_alert;
		@(posedge clock) disable iff (!resetn)
		(st_q == ST_ERROR && !$past(blanked)) |-> !fault_alert_n;
	endproperty
	alert_on_error_a: assert property (p_alert)
		else $error("alert not asserted in error");

	blank_outputs_a: assert property (@(posedge clock) disable iff (!resetn)
		$past(blanked) |-> (fault_alert_n && attach_detect_n &&
		charging_active_n))
		else $error("output asserted during blanking");

	core_low_open_a: assert property (@(posedge clock) disable iff (!resetn)
		!$past(core_supply_ok) |-> !data_switch_closed)
		else $error("data switch closed on low core");

	detect_open_a: assert property (@(posedge clock) disable iff (!resetn)
		(st_q == ST_DETECT || st_q == ST_SLEEP) |->
		!data_switch_closed)
		else $error("data switch closed in detect");

	limit_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		init_q && $past(init_q) |-> $stable(lim_q))
		else $error("current limit changed");

	soft_start_a: assert property (@(posedge clock) disable iff (!resetn)
		en_rise |-> ##2 soft_start [*8])
		else $error("soft start missing");

	trip_open_a: assert property (@(posedge clock) disable iff (!resetn)
		ovl_trip |-> ##1 !power_switch_on)
		else $error("switch on during trip");

	filter_a: assert property (@(posedge clock) disable iff (!resetn)
		(st_q == ST_ACTIVE && !thermal_shutdown && mask_q == '0)
		|-> ##1 st_q != ST_ERROR)
		else $error("error entered without filtering");

	alert_release_a: assert property (@(posedge clock)
		disable iff (!resetn)
		st_q != ST_ERROR |-> fault_alert_n)
		else $error("alert held outside error");

	charge_on_a: assert property (@(posedge clock)
		disable iff (!resetn)
		(!$past(blanked) && $past(charging)) |-> !charging_active_n)
		else $error("charging indicator not asserted");

	charge_off_a: assert property (@(posedge clock)
		disable iff (!resetn)
		!$past(charging) |-> charging_active_n)
		else $error("charging indicator without charging");

	sleep_attach_a: assert property (@(posedge clock)
		disable iff (!resetn)
		(st_q == ST_SLEEP && $past(st_q) == ST_SLEEP) |-> attach_detect_n)
		else $error("attach indicator held in sleep");

	switch_active_a: assert property (@(posedge clock)
		disable iff (!resetn)
		(st_q == ST_ACTIVE && $past(core_supply_ok) &&
		($past(active_mode) == MODE_PASS ||
		$past(active_mode) == MODE_CDP)) |-> data_switch_closed)
		else $error("data switch open in active");

	power_active_a: assert property (@(posedge clock)
		disable iff (!resetn)
		(st_q == ST_ACTIVE && !$past(discharging) && !$past(over_limit) &&
		!$past(thermal_shutdown) && !$past(thermal_regulation) &&
		!$past(bus_low)) |-> power_switch_on)
		else $error("power switch off in active");

	limit_decode_a: assert property (@(posedge clock)
		disable iff (!resetn)
		(init_q && !$past(init_q)) |->
		lim_q == LIM_TABLE[$past(current_limit_select)])
		else $error("current limit decoded wrongly");

	error_off_a: assert property (@(posedge clock)
		disable iff (!resetn)
		st_q == ST_ERROR |->
		(!power_switch_on && !data_switch_closed && !bypass_on))
		else $error("switch on in error");

	detect_bypass_a: assert property (@(posedge clock)
		disable iff (!resetn)
		st_q == ST_DETECT |-> (bypass_on && current_clamp))
		else $error("bypass path not used in detect");

endmodule : pps_ctrl

// ---- test/pps_partner.sv ----
// model of the attached portable device on the port
`timescale 1ns/1ns
module pps_partner (
	input  wire logic clock,
	input  wire logic plug,
	output logic      attach_event,
	output logic      removal_event,
	output logic      charging
);
	logic plug_q = 1'b0;

	// ==========================================================
	// attach and removal pulses
	// remember last plug level to spot edges
	always @(posedge clock) begin
		plug_q <= plug;
	end
	assign attach_event  = plug & ~plug_q;
	assign removal_event = ~plug & plug_q;
	// device draws charge while it stays plugged
	assign charging      = plug_q;
endmodule : pps_partner

// ---- test/tb_top.sv ----
// self-checking bench for the port power control block
`timescale 1ns/1ns
module tb_top;
	import pps_pkg::*;
	// ==========================================================
	// signals
	logic clock = 0, resetn = 0, enable_polarity_select = 1, plug = 0;
	logic [2:0] current_limit_select = 0;
	logic [1:0] active_mode = 1;
	logic port_power_enable = 1, detect_feature_select = 0;
	logic sleep_request = 0, latch_mode = 0, dcp_accepted = 0;
	logic handshake_done = 0, emul_applying = 0, source_supply_ok = 1;
	logic core_supply_ok = 1, over_limit = 0, over_short = 0;
	logic thermal_shutdown = 0, thermal_regulation = 0, other_error = 0;
	logic bus_low = 0, bypass_overload = 0, discharging = 0;
	logic attach_event, removal_event, charging;
	logic fault_alert_n, charging_active_n, attach_detect_n;
	logic data_switch_closed, power_switch_on, bypass_on, soft_start;
	logic current_clamp, cc_mode;
	logic [LIM_W-1:0] current_limit_ma;
	int n_mismatch = 0, checked = 0, seed = 8, n_hi;
	int ma [8] = '{500, 900, 1000, 1200, 1500, 1800, 2000, 2500};

	always #5 clock = ~clock;
	pps_ctrl dut_u (.*);
	pps_partner far_u (.*);

	// ==========================================================
	// helpers
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	task chk_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask : chk_bit
	task chk_lim(input logic [LIM_W-1:0] got, input int exp);
		checked++;
		if (got !== exp[LIM_W-1:0]) begin
			n_mismatch++;
			$display("unexpected %0t limit", $time);
		end
	endtask : chk_lim
	task wait_alert(input logic v);
		for (int k = 0; k < 20000 && fault_alert_n !== v; k++) cyc(1);
		if (fault_alert_n !== v) begin
			n_mismatch++;
			$display("unexpected %0t alert wait", $time);
		end
	endtask : wait_alert
	task wait_on;
		for (int k = 0; k < 20000 && power_switch_on !== 1'b1; k++) cyc(1);
		if (power_switch_on !== 1'b1) begin
			n_mismatch++;
			$display("unexpected %0t power wait", $time);
		end
	endtask : wait_on
	task wrap_up;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	// watchdog against a hang
	initial begin
		#900000;
		n_mismatch++;
		wrap_up;
	end

	// ==========================================================
	// main sequence
	initial begin
		// selection levels, later changes ignored
		for (int i = 0; i < 8; i++) begin
			current_limit_select = i[2:0];
			resetn = 0;
			cyc(2);
			resetn = 1;
			cyc(2);
			current_limit_select = 3'($random(seed));
			cyc(3);
			chk_lim(current_limit_ma, ma[i]);
		end
		$display("test limits done");
		// indicators quiet during blanking
		plug = 1;
		resetn = 0;
		cyc(2);
		resetn = 1;
		cyc(BLANK_CYCLES - 100);
		// a real error inside the blanking window stays silent
		thermal_shutdown = 1;
		cyc(3);
		chk_bit(fault_alert_n, 1, "alert blank");
		chk_bit(power_switch_on, 0, "thermal blank");
		thermal_shutdown = 0;
		cyc(3);
		chk_bit(charging_active_n, 1, "charge blank");
		chk_bit(attach_detect_n, 1, "attach blank");
		cyc(200);
		chk_bit(charging_active_n, 0, "charge");
		chk_bit(attach_detect_n, 0, "attach active");
		chk_bit(data_switch_closed, 1, "switch");
		chk_bit(power_switch_on, 1, "power");
		$display("test blanking done");
		// filtered errors, then release
		for (int e = 1; e < 3; e++) begin
			{over_short, other_error} = e[1:0];
			cyc(MASK_CYCLES - 3);
			chk_bit(fault_alert_n, 1, "alert early");
			chk_bit(current_clamp, e == 2, "clamp");
			cyc(8);
			chk_bit(fault_alert_n, 0, "alert");
			chk_bit(data_switch_closed, 0, "switch err");
			{over_short, other_error} = 2'h0;
			wait_alert(1);
			chk_bit(fault_alert_n, 1, "release");
			wait_on;
		end
		thermal_shutdown = 1;
		cyc(3);
		chk_bit(fault_alert_n, 0, "thermal");
		thermal_shutdown = 0;
		wait_alert(1);
		wait_on;
		$display("test errors done");
		core_supply_ok = 0;
		cyc(3);
		chk_bit(data_switch_closed, 0, "core low");
		core_supply_ok = 1;
		// discharge opens the power switch
		discharging = 1;
		cyc(3);
		chk_bit(power_switch_on, 0, "discharge");
		discharging = 0;
		handshake_done = 1;
		// every mode: switch and limiting kind
		for (int m = 3; m >= 0; m--) begin
			active_mode = m[1:0];
			emul_applying = (m == 3);
			cyc(20);
			wait_on;
			chk_bit(data_switch_closed, m < 2, "mode sw");
			chk_bit(cc_mode, m == 1 || m == 3, "mode cc");
		end
		// no handshake forces trip, accepted dcp depends on limit
		active_mode = 1;
		handshake_done = 0;
		cyc(3);
		chk_bit(cc_mode, 0, "no handshake");
		handshake_done = 1;
		active_mode = 2;
		dcp_accepted = 1;
		cyc(3);
		chk_bit(cc_mode, ma[current_limit_select] <= 1500, "dcp cc");
		dcp_accepted = 0;
		active_mode = 0;
		cyc(3);
		$display("test modes done");
		// trip in pass mode with latched handling
		latch_mode = 1;
		over_limit = 1;
		cyc(3);
		chk_bit(power_switch_on, 0, "trip");
		cyc(MASK_CYCLES + 5);
		chk_bit(fault_alert_n, 0, "trip alert");
		over_limit = 0;
		cyc(100);
		chk_bit(fault_alert_n, 0, "latched");
		port_power_enable = 0;
		cyc(3);
		port_power_enable = 1;
		wait_alert(1);
		chk_bit(fault_alert_n, 1, "recover");
		wait_on;
		port_power_enable = 0;
		cyc(5);
		port_power_enable = 1;
		cyc(3);
		chk_bit(soft_start, 1, "soft on");
		cyc(RISE_CYCLES + 10);
		chk_bit(soft_start, 0, "soft off");
		$display("test trip done");
		// constant current opens on heat
		active_mode = 1;
		wait_on;
		thermal_regulation = 1;
		cyc(3);
		chk_bit(power_switch_on, 0, "heat");
		thermal_regulation = 0;
		// attach held until removal or sleep
		detect_feature_select = 1;
		plug = 0;
		cyc(10);
		chk_bit(attach_detect_n, 1, "removed");
		chk_bit(charging_active_n, 1, "charge off");
		chk_bit(bypass_on, 1, "bypass");
		chk_bit(current_clamp, 1, "detect clamp");
		chk_bit(power_switch_on, 0, "detect off");
		plug = 1;
		cyc(10);
		chk_bit(attach_detect_n, 0, "attached");
		// bypass overload with no source: indicator cycles evenly
		source_supply_ok = 0;
		bypass_overload = 1;
		cyc(40);
		n_hi = 0;
		for (int k = 0; k < 64; k++) begin
			n_hi += attach_detect_n;
			cyc(1);
		end
		chk_bit(n_hi == 32, 1, "toggle");
		bypass_overload = 0;
		source_supply_ok = 1;
		cyc(10);
		sleep_request = 1;
		cyc(10);
		chk_bit(attach_detect_n, 1, "sleep");
		chk_bit(data_switch_closed, 0, "sleep switch");
		$display("test attach done");
		// enable strapped active low, later strap changes ignored
		sleep_request = 0;
		detect_feature_select = 0;
		enable_polarity_select = 0;
		port_power_enable = 0;
		resetn = 0;
		cyc(2);
		resetn = 1;
		cyc(2);
		enable_polarity_select = 1'($random(seed));
		cyc(5);
		chk_bit(power_switch_on, 1, "low enable");
		port_power_enable = 1;
		cyc(3);
		chk_bit(power_switch_on, 0, "low disable");
		$display("test polarity done");
		wrap_up;
	end
endmodule : tb_top
